// ===== logic/drive_stepper.sv
`timescale 1ns/10ps
module drive_stepper
    import led_loop_pkg::*;
(
    // Loop inputs
    input  wire logic [6:0] i_ceiling,
    input  wire logic [6:0] i_actual,
    input  wire logic       i_above,
    input  wire logic       i_below,
    // Result
    output logic      [6:0] o_next
);

    always_comb begin
        o_next = i_actual;
        if (i_above && i_actual != CODE_ZERO) begin
            o_next = i_actual - CODE_ONE;
        end else if (i_below && !i_above && i_actual < i_ceiling) begin
            o_next = i_actual + CODE_ONE;
        end
        if (o_next > i_ceiling) begin
            o_next = i_ceiling;
        end
    end

endmodule

// ===== logic/led_drive_loop_alarm.sv
`timescale 1ns/10ps
// Contract
// - Bit 7 picks fixed or closed loop
// - Control all zeros turns sink off
// - Fixed mode sinks low seven-bit code
// - Loop start loads seven eighths ceiling
// - Above target lowers drive one step
// - Below target under ceiling raises one
// - Drive clamped to ceiling code one cycle after ceiling drops
// - Updates every 16 s, fast 1 s
// - Readback shows actual drive code
// - Readback top bit mirrors mode bit
// - Drive over seven eighths sets bit6
// - Target field sets regulation level
// - Four alarm sources detected
// - Shutdown alarm holds until power cycle
// - Shutdown turns off all current
// - Status sticky, cleared by read
// - Unmasked alarms pull interrupt low
// - Power-up alarm is unmaskable
// - Mask zero suppresses, one allows
// - Pin released when alarm ends
// - Status bits 7..4, masks 2..0
module led_drive_loop_alarm
    import led_loop_pkg::*;
#(
    parameter longint SLOW_CNT = SLOW_CYCLES,
    parameter longint FAST_CNT = FAST_CYCLES
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    // Register access
    input  wire reg_req_t    i_reg,
    output logic      [7:0]  o_rdata,
    output logic             o_rvalid,
    // Amplitude comparator
    input  wire logic        i_amp_above,
    input  wire logic        i_amp_below,
    // Alarm sources
    input  wire alarm_in_t   i_alarm,
    // LED sink and analog controls
    output logic      [6:0]  o_sink_code,
    output logic             o_sink_en,
    output logic      [3:0]  o_amplitude_target_sel,
    output logic      [1:0]  o_feedback_ref_sel,
    output logic      [1:0]  o_low_level_sel,
    output logic             o_power_off,
    // Interrupt pin, open drain
    input  wire logic        i_irq_n_pin,
    output logic             o_irq_n_pin,
    output logic             o_irq_n_pin_oe
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]       drive_control_reg;
        logic [7:0]       loop_target_reg;
        logic [2:0]       mask;
        logic [3:0]       status;
        logic [6:0]       drive_code_actual;
        logic             loop_run;
        logic [TMR_W-1:0] timer;
        logic             tsd_latch;
        logic             amp_above;
        logic             amp_below;
        logic [7:0]       rdata;
        logic             rvalid;
        logic [6:0]       sink_code;
        logic             sink_en;
        logic             power_off;
        logic             irq_oe;
    } state_t;

    state_t st_ff;
    state_t nxt_st;

    localparam state_t ST_RST = '{
        drive_control_reg: DRIVE_CTRL_RST,
        loop_target_reg:   LOOP_TARGET_RST,
        mask:              MASK_RST,
        status:            STATUS_RST,
        drive_code_actual: CODE_ZERO,
        loop_run:          1'b0,
        timer:             '0,
        tsd_latch:         1'b0,
        amp_above:         1'b0,
        amp_below:         1'b0,
        rdata:             8'h00,
        rvalid:            1'b0,
        sink_code:         CODE_ZERO,
        sink_en:           1'b0,
        power_off:         1'b0,
        irq_oe:            1'b0
    };

    logic [6:0] step_code;

    function automatic logic [6:0] seven_eighths(input logic [6:0] code);
        logic [9:0] prod;
        prod = {3'h0, code} * 10'h007;
        return prod[9:3];
    endfunction

    function automatic logic [TMR_W-1:0] period_of(input logic fast);
        return fast ? TMR_W'(FAST_CNT - 1) : TMR_W'(SLOW_CNT - 1);
    endfunction

    drive_stepper u_step (
        .i_ceiling (st_ff.drive_control_reg[6:0]),
        .i_actual  (st_ff.drive_code_actual),
        .i_above   (st_ff.amp_above),
        .i_below   (st_ff.amp_below),
        .o_next    (step_code)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic       closed;
    logic       loop_alarm;
    logic       tsd_now;
    logic [3:0] cause;
    logic [7:0] irq_reg;
    logic       tick;

    always_comb begin
        nxt_st = st_ff;
        closed = st_ff.drive_control_reg[LOOP_MODE_BIT];
        tick = closed && st_ff.loop_run && (st_ff.timer == '0);
        loop_alarm = closed && st_ff.loop_run
                     && (st_ff.drive_code_actual > seven_eighths(st_ff.drive_control_reg[6:0]));
        tsd_now = st_ff.tsd_latch || i_alarm.shutdown;
        cause = {i_alarm.powerup, loop_alarm, i_alarm.over_temp, tsd_now};
        irq_reg = {st_ff.status, 1'b0, st_ff.mask};
        nxt_st.tsd_latch = tsd_now;

        // Register access; read of the interrupt register clears status
        nxt_st.rvalid = 1'b0;
        if (i_reg.req && i_reg.wr) begin
            unique case (i_reg.addr)
                ADDR_DRIVE_CONTROL: nxt_st.drive_control_reg = i_reg.wdata;
                ADDR_LOOP_TARGET:   nxt_st.loop_target_reg = i_reg.wdata;
                ADDR_IRQ_MASK_STAT: nxt_st.mask = i_reg.wdata[2:0];
                default:            nxt_st.mask = st_ff.mask;
            endcase
        end
        if (i_reg.req && !i_reg.wr) begin
            nxt_st.rvalid = 1'b1;
            unique case (i_reg.addr)
                ADDR_DRIVE_CONTROL:  nxt_st.rdata = st_ff.drive_control_reg;
                ADDR_LOOP_TARGET:    nxt_st.rdata = st_ff.loop_target_reg;
                ADDR_IRQ_MASK_STAT:  nxt_st.rdata = irq_reg;
                ADDR_DRIVE_READBACK: nxt_st.rdata = {closed, st_ff.drive_code_actual};
                default:             nxt_st.rdata = 8'h00;
            endcase
            if (i_reg.addr == ADDR_IRQ_MASK_STAT) begin
                nxt_st.status = 4'h0;
            end
        end
        nxt_st.status = nxt_st.status | cause;

        // Drive loop
        if (!closed) begin
            nxt_st.loop_run = 1'b0;
            nxt_st.drive_code_actual = st_ff.drive_control_reg[6:0];
        end else if (!st_ff.loop_run) begin
            nxt_st.loop_run = 1'b1;
            nxt_st.drive_code_actual = seven_eighths(st_ff.drive_control_reg[6:0]);
            nxt_st.timer = period_of(st_ff.loop_target_reg[FAST_BIT]);
        end else if (tick) begin
            nxt_st.timer = period_of(st_ff.loop_target_reg[FAST_BIT]);
            nxt_st.drive_code_actual = step_code;
        end else begin
            nxt_st.timer = st_ff.timer - TMR_W'(1);
            if (st_ff.drive_code_actual > st_ff.drive_control_reg[6:0]) begin
                nxt_st.drive_code_actual = st_ff.drive_control_reg[6:0];
            end
        end
        // Comparator decisions captured one cycle before each update
        if (closed && st_ff.loop_run && st_ff.timer == TMR_W'(1)) begin
            nxt_st.amp_above = i_amp_above;
            nxt_st.amp_below = i_amp_below;
        end

        // Sink drive and power
        nxt_st.power_off = tsd_now;
        nxt_st.sink_code = nxt_st.drive_code_actual;
        nxt_st.sink_en = (nxt_st.drive_control_reg != DRIVE_CTRL_RST)
                         && !tsd_now;

        // Interrupt pin follows live unmasked causes
        nxt_st.irq_oe = !(cause[3]
                          || (cause[2] && st_ff.mask[MSK_LOOP_BIT])
                          || (cause[1] && st_ff.mask[MSK_TALM_BIT])
                          || (cause[0] && st_ff.mask[MSK_TSD_BIT]));
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            st_ff <= ST_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_rdata                = st_ff.rdata;
    assign o_rvalid               = st_ff.rvalid;
    assign o_sink_code            = st_ff.sink_code;
    assign o_sink_en              = st_ff.sink_en;
    assign o_amplitude_target_sel = {1'b0, st_ff.loop_target_reg[2:0]};
    assign o_low_level_sel        = st_ff.loop_target_reg[4:3];
    assign o_feedback_ref_sel     = st_ff.loop_target_reg[6:5];
    assign o_power_off            = st_ff.power_off;
    assign o_irq_n_pin            = 1'b0;
    assign o_irq_n_pin_oe         = st_ff.irq_oe;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_ceiling_held: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $past(closed) && st_ff.loop_run |-> st_ff.drive_code_actual <= st_ff.drive_control_reg[6:0]
        || $changed(st_ff.drive_control_reg))
        else $error("drive above ceiling");
    a_fixed_follow: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !closed |=> st_ff.drive_code_actual == $past(st_ff.drive_control_reg[6:0]))
        else $error("fixed drive mismatch");
    a_loop_init: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        closed && !st_ff.loop_run |=> st_ff.drive_code_actual
        == seven_eighths($past(st_ff.drive_control_reg[6:0])))
        else $error("loop start value wrong");
    a_zero_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        st_ff.drive_control_reg == 8'h00 |-> !o_sink_en)
        else $error("sink on at zero control");
    a_tsd_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        st_ff.tsd_latch |=> st_ff.tsd_latch && st_ff.power_off && !o_sink_en)
        else $error("shutdown released");
    a_pwr_irq: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_alarm.powerup |=> !o_irq_n_pin_oe)
        else $error("power-up irq not driven");
    a_status_set: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_alarm.over_temp |=> st_ff.status[1])
        else $error("status not set");
    a_irq_release: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        cause == 4'h0 |=> o_irq_n_pin_oe)
        else $error("irq held without alarm");
    a_step_down: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        tick && st_ff.amp_above && st_ff.drive_code_actual != CODE_ZERO
        && st_ff.drive_code_actual <= st_ff.drive_control_reg[6:0]
        |=> st_ff.drive_code_actual == $past(st_ff.drive_code_actual) - CODE_ONE)
        else $error("drive not lowered");
    a_step_up: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        tick && st_ff.amp_below && !st_ff.amp_above
        && st_ff.drive_code_actual < st_ff.drive_control_reg[6:0]
        |=> st_ff.drive_code_actual == $past(st_ff.drive_code_actual) + CODE_ONE)
        else $error("drive not raised");
    a_hold_between: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        closed && st_ff.loop_run && !tick
        && st_ff.drive_code_actual <= st_ff.drive_control_reg[6:0]
        |=> $stable(st_ff.drive_code_actual))
        else $error("drive moved between updates");
    a_timer_restart: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        closed && !st_ff.loop_run |=> st_ff.loop_run
        && st_ff.timer == period_of($past(st_ff.loop_target_reg[FAST_BIT])))
        else $error("update timer not restarted");
    a_amp_sample: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        closed && st_ff.loop_run && st_ff.timer == TMR_W'(1)
        |=> st_ff.amp_above == $past(i_amp_above) && st_ff.amp_below == $past(i_amp_below))
        else $error("amplitude decision not sampled");
    a_readback_map: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_reg.req && !i_reg.wr && i_reg.addr == ADDR_DRIVE_READBACK
        |=> o_rvalid && o_rdata == {$past(closed), $past(st_ff.drive_code_actual)})
        else $error("readback value wrong");
    a_loop_status: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        loop_alarm |=> st_ff.status[2])
        else $error("loop status not set");
    a_status_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_reg.req && !i_reg.wr && i_reg.addr == ADDR_IRQ_MASK_STAT && cause == 4'h0
        |=> st_ff.status == 4'h0)
        else $error("status not cleared by read");
    a_masked_quiet: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        st_ff.mask == 3'h0 && !i_alarm.powerup |=> o_irq_n_pin_oe)
        else $error("masked alarm drove irq");
    a_unmasked_low: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_alarm.over_temp && st_ff.mask[MSK_TALM_BIT] |=> !o_irq_n_pin_oe)
        else $error("unmasked alarm left irq high");
    a_power_cut: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        tsd_now |=> o_power_off && !o_sink_en)
        else $error("shutdown left power on");

endmodule

// ===== logic/led_loop_pkg.sv
package led_loop_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_DRIVE_CONTROL  = 16'h0886;
    localparam logic [15:0] ADDR_LOOP_TARGET    = 16'h0887;
    localparam logic [15:0] ADDR_IRQ_MASK_STAT  = 16'h0889;
    localparam logic [15:0] ADDR_DRIVE_READBACK = 16'h088F;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int          LOOP_MODE_BIT   = 7;
    localparam int          FAST_BIT        = 7;
    localparam int          ST_PWR_BIT      = 7;
    localparam int          ST_LOOP_BIT     = 6;
    localparam int          ST_TALM_BIT     = 5;
    localparam int          ST_TSD_BIT      = 4;
    localparam int          MSK_LOOP_BIT    = 2;
    localparam int          MSK_TALM_BIT    = 1;
    localparam int          MSK_TSD_BIT     = 0;
    localparam logic [7:0]  DRIVE_CTRL_RST  = 8'h00;
    localparam logic [7:0]  LOOP_TARGET_RST = 8'h40;
    localparam logic [2:0]  MASK_RST        = 3'h0;
    localparam logic [6:0]  CODE_ZERO       = 7'h00;
    localparam logic [6:0]  CODE_ONE        = 7'h01;
    localparam logic [3:0]  STATUS_RST      = 4'h8;

    // ------------------------------------------------------------
    // Loop update timing
    // ------------------------------------------------------------
    localparam longint CLK_HZ          = 100_000_000;
    localparam longint SLOW_PERIOD_S   = 16;
    localparam longint FAST_PERIOD_S   = 1;
    localparam longint SLOW_CYCLES     = SLOW_PERIOD_S * CLK_HZ;
    localparam longint FAST_CYCLES     = FAST_PERIOD_S * CLK_HZ;
    localparam int     TMR_W           = 31;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       req;
        logic       wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic       powerup;
        logic       over_temp;
        logic       shutdown;
    } alarm_in_t;

endpackage

// ===== tb/irq_line_model.sv
`timescale 1ns/10ps
module irq_line_model (
    // Device side of the open-drain pin
    input  wire logic i_drv,
    input  wire logic i_oe_n,
    // Resolved line level
    output logic      o_line
);
    // Pull-up holds the line high whenever the device lets go
    assign o_line = i_oe_n ? 1'h1 : i_drv;
endmodule

// ===== tb/led_drive_loop_alarm_tb_top.sv
`timescale 1ns/10ps
module led_drive_loop_alarm_tb_top import led_loop_pkg::*;;
    localparam longint SLOW = 40;
    localparam longint FAST = 10;
    logic       i_clk = 1'h0;
    logic       i_rst_n;
    reg_req_t   i_reg;
    logic       i_amp_above;
    logic       i_amp_below;
    alarm_in_t  i_alarm;
    logic [7:0] o_rdata;
    logic       o_rvalid;
    logic [6:0] o_sink_code;
    logic       o_sink_en;
    logic [3:0] o_amplitude_target_sel;
    logic [1:0] o_feedback_ref_sel;
    logic [1:0] o_low_level_sel;
    logic       o_power_off;
    logic       o_irq_n_pin;
    logic       o_irq_n_pin_oe;
    logic       irq_line;
    int         miscompares = 0;
    int         cmp_count = 0;
    int         cycles = 0;
    int         n;

    always #5 i_clk = ~i_clk;

    led_drive_loop_alarm #(.SLOW_CNT(SLOW), .FAST_CNT(FAST)) u_led_drive_loop_alarm (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg(i_reg), .o_rdata(o_rdata),
        .o_rvalid(o_rvalid), .i_amp_above(i_amp_above), .i_amp_below(i_amp_below),
        .i_alarm(i_alarm), .o_sink_code(o_sink_code), .o_sink_en(o_sink_en),
        .o_amplitude_target_sel(o_amplitude_target_sel),
        .o_feedback_ref_sel(o_feedback_ref_sel), .o_low_level_sel(o_low_level_sel),
        .o_power_off(o_power_off), .i_irq_n_pin(irq_line),
        .o_irq_n_pin(o_irq_n_pin), .o_irq_n_pin_oe(o_irq_n_pin_oe));

    irq_line_model u_irq_line_model (.i_drv(o_irq_n_pin), .i_oe_n(o_irq_n_pin_oe),
        .o_line(irq_line));

    // ------------------------------------------------------------
    // Check and access tasks
    // ------------------------------------------------------------
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_reg <= '{req: 1'h1, wr: 1'h1, addr: a, wdata: d};
        @(posedge i_clk);
        i_reg <= '0;
        @(posedge i_clk);
        #1;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        int k;
        @(posedge i_clk);
        i_reg <= '{req: 1'h1, wr: 1'h0, addr: a, wdata: 8'h00};
        @(posedge i_clk);
        i_reg <= '0;
        k = 0;
        #1;
        while (o_rvalid !== 1'h1 && k < 4) begin
            @(posedge i_clk);
            #1;
            k++;
        end
        chk(o_rdata, e);
    endtask

    task automatic pin(input logic e);
        repeat (2) @(posedge i_clk);
        #1;
        chk({7'h00, irq_line}, {7'h00, e});
    endtask

    task automatic wait_code(input logic [6:0] e);
        n = 0;
        do begin
            @(posedge i_clk);
            #1;
            n++;
        end while (o_sink_code !== e && n < 600);
        chk({1'h0, o_sink_code}, {1'h0, e});
    endtask

    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            summarize();
        end
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        i_rst_n = 1'h0;
        i_reg = '0;
        i_amp_above = 1'h0;
        i_amp_below = 1'h0;
        i_alarm = '{powerup: 1'h1, over_temp: 1'h0, shutdown: 1'h0};
        repeat (5) @(posedge i_clk);
        i_rst_n <= 1'h1;
        pin(1'h0);
        @(posedge i_clk);
        i_alarm.powerup <= 1'h0;
        pin(1'h1);
        rd(ADDR_IRQ_MASK_STAT, 8'h80);
        rd(ADDR_IRQ_MASK_STAT, 8'h00);
        rd(ADDR_DRIVE_CONTROL, DRIVE_CTRL_RST);
        rd(ADDR_LOOP_TARGET, LOOP_TARGET_RST);
        rd(16'h0880, 8'h00);
        $display("Test reset done");
        wr(ADDR_DRIVE_CONTROL, 8'h55);
        chk({o_sink_en, o_sink_code}, 8'hD5);
        rd(ADDR_DRIVE_READBACK, 8'h55);
        wr(ADDR_DRIVE_READBACK, 8'hFF);
        wr(ADDR_DRIVE_CONTROL, 8'h7F);
        rd(ADDR_DRIVE_READBACK, 8'h7F);
        wr(ADDR_DRIVE_CONTROL, 8'h00);
        chk({7'h00, o_sink_en}, 8'h00);
        $display("Test fixed drive done");
        wr(ADDR_LOOP_TARGET, 8'h44);
        chk({o_low_level_sel, o_feedback_ref_sel, o_amplitude_target_sel}, 8'h24);
        wr(ADDR_IRQ_MASK_STAT, 8'h04);
        @(posedge i_clk);
        i_amp_below <= 1'h1;
        wr(ADDR_DRIVE_CONTROL, 8'hC0);
        chk({1'h0, o_sink_code}, 8'h38);
        rd(ADDR_DRIVE_READBACK, 8'hB8);
        wait_code(7'h39);
        chk(8'(n), 8'(SLOW - 2));
        pin(1'h0);
        wait_code(7'h3A);
        chk(8'(n), 8'(SLOW - 2));
        wait_code(7'h40);
        repeat (3 * SLOW) @(posedge i_clk);
        chk({1'h0, o_sink_code}, 8'h40);
        i_amp_below <= 1'h0;
        i_amp_above <= 1'h1;
        wait_code(7'h3F);
        wr(ADDR_LOOP_TARGET, 8'hC4);
        wait_code(7'h3E);
        repeat (2) @(posedge i_clk);
        wait_code(7'h3D);
        chk(8'(n), 8'(FAST - 2));
        @(posedge i_clk);
        i_amp_above <= 1'h0;
        rd(ADDR_IRQ_MASK_STAT, 8'h44);
        wr(ADDR_DRIVE_CONTROL, 8'h00);
        pin(1'h1);
        $display("Test closed loop done");
        wr(ADDR_IRQ_MASK_STAT, 8'h00);
        rd(ADDR_IRQ_MASK_STAT, 8'h40);
        rd(ADDR_IRQ_MASK_STAT, 8'h00);
        @(posedge i_clk);
        i_alarm.over_temp <= 1'h1;
        pin(1'h1);
        wr(ADDR_IRQ_MASK_STAT, 8'h02);
        pin(1'h0);
        @(posedge i_clk);
        i_alarm.over_temp <= 1'h0;
        pin(1'h1);
        rd(ADDR_IRQ_MASK_STAT, 8'h22);
        rd(ADDR_IRQ_MASK_STAT, 8'h02);
        $display("Test thermal alarm done");
        @(posedge i_clk);
        i_alarm.shutdown <= 1'h1;
        pin(1'h1);
        chk({7'h00, o_power_off}, 8'h01);
        @(posedge i_clk);
        i_alarm.shutdown <= 1'h0;
        wr(ADDR_IRQ_MASK_STAT, 8'h01);
        pin(1'h0);
        chk({7'h00, o_power_off}, 8'h01);
        wr(ADDR_DRIVE_CONTROL, 8'h55);
        chk({o_sink_en, o_sink_code}, 8'h55);
        rd(ADDR_IRQ_MASK_STAT, 8'h11);
        $display("Test shutdown done");
        summarize();
    end
endmodule
